// [tpwm_pkg.sv]
// Shared constants and types for the 8-bit PWM timer
package tpwm_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CMP = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_PIN = 8'h10;

	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_COM_LSB = 2;
	localparam int CTRL_CS_LSB = 4;
	localparam int CTRL_FORCE_BIT = 7;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	localparam int PIN_DIR_BIT = 0;
	localparam int PIN_PORT_BIT = 1;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [7:0] PIN_RESET = 8'h00;

	// Counter limits
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// Prescaler masks for divide by 8, 64, 256 and 1024
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_64 = 10'h03F;
	localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_PC_PWM = 2'h1,
		MODE_CTC = 2'h2,
		MODE_FAST_PWM = 2'h3
	} tpwm_mode_t;

	typedef enum logic [1:0] {
		COM_OFF = 2'h0,
		COM_TOGGLE = 2'h1,
		COM_CLEAR = 2'h2,
		COM_SET = 2'h3
	} tpwm_com_t;

	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} tpwm_cs_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} tpwm_dir_t;

endpackage

// [tpwm_prescaler.sv]
// Timer clock enable generator: prescaler and external edge source
`timescale 1ns/1ps
module tpwm_prescaler #(
	parameter int PRE_WIDTH = 10
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Source selection
	input wire logic [2:0] clock_sel,
	input wire logic ext_clock_in,
	// Enable out
	output logic timer_clock_enable
);

	logic [PRE_WIDTH-1:0] pre_reg;
	logic ext_prev_reg;

	function automatic logic pre_hit(input logic [PRE_WIDTH-1:0] cnt,
		input logic [PRE_WIDTH-1:0] mask);
		pre_hit = (cnt & mask) == mask;
	endfunction

	// Free running divider, cleared while stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= '0;
		end else if (clock_sel == tpwm_pkg::CS_STOP) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_clock_in;
		end
	end

	// One-cycle enable per timer tick
	always_comb begin
		unique case (tpwm_pkg::tpwm_cs_t'(clock_sel))
			tpwm_pkg::CS_STOP: timer_clock_enable = 1'b0;
			tpwm_pkg::CS_DIV1: timer_clock_enable = 1'b1;
			tpwm_pkg::CS_DIV8: timer_clock_enable = pre_hit(pre_reg, tpwm_pkg::PRE_MASK_8);
			tpwm_pkg::CS_DIV64: timer_clock_enable = pre_hit(pre_reg, tpwm_pkg::PRE_MASK_64);
			tpwm_pkg::CS_DIV256: timer_clock_enable = pre_hit(pre_reg, tpwm_pkg::PRE_MASK_256);
			tpwm_pkg::CS_DIV1024: timer_clock_enable = pre_hit(pre_reg, tpwm_pkg::PRE_MASK_1024);
			tpwm_pkg::CS_EXT_FALL: timer_clock_enable = ext_prev_reg & ~ext_clock_in;
			tpwm_pkg::CS_EXT_RISE: timer_clock_enable = ~ext_prev_reg & ext_clock_in;
		endcase
	end

endmodule // tpwm_prescaler

// [tpwm_core.sv]
// 8-bit timer with fast and phase correct PWM, APB registers
// Notes on behaviour
// - Mode 3 counts up from bottom to max, then restarts at bottom.
// - Fast non-inverting: clear output on match, set at bottom.
// - Fast inverting: set output on match, clear at bottom.
// - Fast mode: counter at max clears to bottom on next tick.
// - Fast mode sets overflow flag each time the counter reaches max.
// - Output mode two is non-inverted, three is inverted, in both PWM modes.
// - Output reaches the pin only while the pin direction is output.
// - Fast period is 256 ticks.
// - Tick is the I/O clock divided by 1, 8, 64, 256 or 1024, or an edge of the external clock.
// - Fast compare zero gives a one-tick spike; max gives a constant level.
// - Fast mode with output mode one toggles on every match.
// - Fast compare value is double buffered, loaded at bottom.
// - Mode 1 counts up bottom to max, then down to bottom, repeatedly.
// - Phase correct non-inverting clears on up match, sets on down match.
// - Phase correct resolution is eight bits; max lasts one tick.
// - Phase correct sets overflow flag each time the counter reaches bottom.
// - Phase correct period is 510 ticks.
// - Phase correct compare zero gives steady low, max steady high, non-inverted.
// - Leaving compare max, output takes the up-match level at max.
// - A missed up-count match still yields its transition at max.
// - All logic runs on pclk; the tick is only a one-cycle enable.
// - Max is 0xFF, bottom is zero.
// - PWM with compare at top ignores the match, acts at period boundary.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module tpwm_core #(
	parameter int ADDR_WIDTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External timer clock source
	input wire logic timer_ext_clock,
	// Waveform pin
	output logic compare_output_pin,
	output logic compare_output_pin_oe
);

	logic [7:0] ctrl_reg;
	logic [7:0] counter_value_reg;
	logic [7:0] cmp_buf_reg;
	logic [7:0] compare_value_reg;
	logic [7:0] pin_cfg_reg;
	logic overflow_flag_reg;
	logic compare_match_flag_reg;
	logic compare_output_reg;
	logic block_reg;
	logic [31:0] prdata_reg;
	tpwm_pkg::tpwm_dir_t dir_reg;

	logic timer_clock_enable;
	tpwm_pkg::tpwm_mode_t waveform_mode_sel;
	tpwm_pkg::tpwm_com_t compare_out_mode;
	logic [7:0] addr8;
	logic sel_ctrl, sel_count, sel_cmp, sel_flags, sel_pin, mapped;
	logic wr, cnt_wr, force_strobe;
	logic is_max, is_bottom, pwm_mode, match_raw;
	logic ovf_set, cmp_set, ovf_clr, cmp_clr;
	logic [31:0] rd_mux;

	// Compare action outside PWM modes
	function automatic logic nonpwm_level(input tpwm_pkg::tpwm_com_t com, input logic cur);
		unique case (com)
			tpwm_pkg::COM_OFF: nonpwm_level = cur;
			tpwm_pkg::COM_TOGGLE: nonpwm_level = ~cur;
			tpwm_pkg::COM_CLEAR: nonpwm_level = 1'b0;
			tpwm_pkg::COM_SET: nonpwm_level = 1'b1;
		endcase
	endfunction

	tpwm_prescaler #(
		.PRE_WIDTH(10)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clock_sel(ctrl_reg[tpwm_pkg::CTRL_CS_LSB +: 3]),
		.ext_clock_in(timer_ext_clock),
		.timer_clock_enable(timer_clock_enable)
	);

	// Field decode
	assign waveform_mode_sel = tpwm_pkg::tpwm_mode_t'(ctrl_reg[tpwm_pkg::CTRL_MODE_LSB +: 2]);
	assign compare_out_mode = tpwm_pkg::tpwm_com_t'(ctrl_reg[tpwm_pkg::CTRL_COM_LSB +: 2]);
	assign pwm_mode = (waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) ||
		(waveform_mode_sel == tpwm_pkg::MODE_PC_PWM);
	assign is_max = counter_value_reg == tpwm_pkg::CNT_MAX;
	assign is_bottom = counter_value_reg == tpwm_pkg::CNT_BOTTOM;
	assign match_raw = (counter_value_reg == compare_value_reg) && !block_reg;

	// Bus decode
	assign addr8 = paddr[7:0];
	assign sel_ctrl = addr8 == tpwm_pkg::ADDR_CTRL;
	assign sel_count = addr8 == tpwm_pkg::ADDR_COUNT;
	assign sel_cmp = addr8 == tpwm_pkg::ADDR_CMP;
	assign sel_flags = addr8 == tpwm_pkg::ADDR_FLAGS;
	assign sel_pin = addr8 == tpwm_pkg::ADDR_PIN;
	assign mapped = (sel_ctrl | sel_count | sel_cmp | sel_flags | sel_pin) &&
		(paddr >> 8) == '0;
	assign wr = psel & penable & pwrite & mapped;
	assign cnt_wr = wr & sel_count;
	assign force_strobe = wr & sel_ctrl & pwdata[tpwm_pkg::CTRL_FORCE_BIT];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_reg;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux[7:0] = ctrl_reg;
		end else if (sel_count) begin
			rd_mux[7:0] = counter_value_reg;
		end else if (sel_cmp) begin
			rd_mux[7:0] = cmp_buf_reg;
		end else if (sel_flags) begin
			rd_mux[tpwm_pkg::FLAG_OVF_BIT] = overflow_flag_reg;
			rd_mux[tpwm_pkg::FLAG_CMP_BIT] = compare_match_flag_reg;
		end else if (sel_pin) begin
			rd_mux[7:0] = pin_cfg_reg;
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= rd_mux;
		end
	end

	// Control register; force strobe is not stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= tpwm_pkg::CTRL_RESET;
		end else if (wr && sel_ctrl) begin
			ctrl_reg <= {1'b0, pwdata[6:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cfg_reg <= tpwm_pkg::PIN_RESET;
		end else if (wr && sel_pin) begin
			pin_cfg_reg <= {6'h00, pwdata[1:0]};
		end
	end

	// Compare buffer written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_buf_reg <= tpwm_pkg::CMP_RESET;
		end else if (wr && sel_cmp) begin
			cmp_buf_reg <= pwdata[7:0];
		end
	end

	// Active compare value: loaded at bottom or top in PWM, at once otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_value_reg <= tpwm_pkg::CMP_RESET;
		end else if (!pwm_mode) begin
			compare_value_reg <= (wr && sel_cmp) ? pwdata[7:0] : cmp_buf_reg;
		end else if (timer_clock_enable && is_max) begin
			compare_value_reg <= cmp_buf_reg;
		end
	end

	// Counter sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_reg <= tpwm_pkg::COUNT_RESET;
		end else if (cnt_wr) begin
			counter_value_reg <= pwdata[7:0];
		end else if (timer_clock_enable) begin
			unique case (waveform_mode_sel)
				tpwm_pkg::MODE_NORMAL: begin
					counter_value_reg <= counter_value_reg + 8'h01;
				end
				tpwm_pkg::MODE_CTC: begin
					counter_value_reg <= (counter_value_reg == compare_value_reg) ?
						tpwm_pkg::CNT_BOTTOM : counter_value_reg + 8'h01;
				end
				tpwm_pkg::MODE_FAST_PWM: begin
					counter_value_reg <= is_max ? tpwm_pkg::CNT_BOTTOM :
						counter_value_reg + 8'h01;
				end
				tpwm_pkg::MODE_PC_PWM: begin
					if (dir_reg == tpwm_pkg::DIR_UP) begin
						counter_value_reg <= is_max ? counter_value_reg - 8'h01 :
							counter_value_reg + 8'h01;
					end else begin
						counter_value_reg <= is_bottom ? counter_value_reg + 8'h01 :
							counter_value_reg - 8'h01;
					end
				end
			endcase
		end
	end

	// Count direction, reversed at max and at bottom
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_reg <= tpwm_pkg::DIR_UP;
		end else if (waveform_mode_sel != tpwm_pkg::MODE_PC_PWM) begin
			dir_reg <= tpwm_pkg::DIR_UP;
		end else if (timer_clock_enable && is_max) begin
			dir_reg <= tpwm_pkg::DIR_DOWN;
		end else if (timer_clock_enable && is_bottom) begin
			dir_reg <= tpwm_pkg::DIR_UP;
		end
	end

	// A counter write blocks the match on the following tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_reg <= 1'b0;
		end else if (cnt_wr) begin
			block_reg <= 1'b1;
		end else if (timer_clock_enable) begin
			block_reg <= 1'b0;
		end
	end

	// Flags: write one to clear, a set in the same cycle wins
	assign ovf_set = timer_clock_enable &&
		((waveform_mode_sel == tpwm_pkg::MODE_PC_PWM) ? is_bottom : is_max);
	assign cmp_set = timer_clock_enable && match_raw;
	assign ovf_clr = wr && sel_flags && pwdata[tpwm_pkg::FLAG_OVF_BIT];
	assign cmp_clr = wr && sel_flags && pwdata[tpwm_pkg::FLAG_CMP_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_reg <= 1'b0;
		end else begin
			overflow_flag_reg <= ovf_set | (overflow_flag_reg & ~ovf_clr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_match_flag_reg <= 1'b0;
		end else begin
			compare_match_flag_reg <= cmp_set | (compare_match_flag_reg & ~cmp_clr);
		end
	end

	// Waveform output register; bit 0 of the output mode picks the polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_output_reg <= 1'b0;
		end else if (force_strobe && !pwm_mode) begin
			compare_output_reg <= nonpwm_level(compare_out_mode, compare_output_reg);
		end else if (timer_clock_enable) begin
			unique case (waveform_mode_sel)
				tpwm_pkg::MODE_FAST_PWM: begin
					if (compare_out_mode == tpwm_pkg::COM_TOGGLE) begin
						if (match_raw) begin
							compare_output_reg <= ~compare_output_reg;
						end
					end else if (compare_out_mode != tpwm_pkg::COM_OFF) begin
						if (is_max) begin
							compare_output_reg <= ~compare_out_mode[0];
						end else if (match_raw && compare_value_reg != tpwm_pkg::CNT_MAX) begin
							compare_output_reg <= compare_out_mode[0];
						end
					end
				end
				tpwm_pkg::MODE_PC_PWM: begin
					if (compare_out_mode[1]) begin
						if (is_max) begin
							compare_output_reg <= (cmp_buf_reg == tpwm_pkg::CNT_MAX) ?
								~compare_out_mode[0] : compare_out_mode[0];
						end else if (match_raw) begin
							compare_output_reg <= (dir_reg == tpwm_pkg::DIR_UP || is_bottom) ?
								compare_out_mode[0] : ~compare_out_mode[0];
						end
					end
				end
				default: begin
					if (match_raw) begin
						compare_output_reg <= nonpwm_level(compare_out_mode, compare_output_reg);
					end
				end
			endcase
		end
	end

	// Pin override and direction gating
	assign compare_output_pin = (compare_out_mode != tpwm_pkg::COM_OFF) ?
		compare_output_reg : pin_cfg_reg[tpwm_pkg::PIN_PORT_BIT];
	assign compare_output_pin_oe = pin_cfg_reg[tpwm_pkg::PIN_DIR_BIT];

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_fast_wrap;
		(waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) && timer_clock_enable && is_max && !cnt_wr
		|=> counter_value_reg == tpwm_pkg::CNT_BOTTOM;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast mode did not wrap");

	property p_fast_ovf;
		(waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) && timer_clock_enable && is_max
		|=> overflow_flag_reg;
	endproperty
	a_fast_ovf: assert property (p_fast_ovf) else $error("fast overflow flag missing");

	property p_pc_top;
		(waveform_mode_sel == tpwm_pkg::MODE_PC_PWM) && timer_clock_enable && is_max &&
		dir_reg == tpwm_pkg::DIR_UP && !cnt_wr
		|=> counter_value_reg == 8'hFE && dir_reg == tpwm_pkg::DIR_DOWN;
	endproperty
	a_pc_top: assert property (p_pc_top) else $error("phase correct top not reversed");

	property p_pc_ovf;
		(waveform_mode_sel == tpwm_pkg::MODE_PC_PWM) && timer_clock_enable && is_bottom
		|=> overflow_flag_reg;
	endproperty
	a_pc_ovf: assert property (p_pc_ovf) else $error("phase correct overflow missing");

	property p_match_flag;
		pwm_mode && timer_clock_enable && counter_value_reg == compare_value_reg && !block_reg
		|=> compare_match_flag_reg;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag missing");

	property p_fast_noninv;
		(waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) &&
		compare_out_mode == tpwm_pkg::COM_CLEAR && timer_clock_enable && is_max && !force_strobe
		|=> compare_output_reg;
	endproperty
	a_fast_noninv: assert property (p_fast_noninv) else $error("not set at bottom");

	property p_fast_inv;
		(waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) &&
		compare_out_mode == tpwm_pkg::COM_SET && timer_clock_enable && match_raw && !is_max &&
		compare_value_reg != tpwm_pkg::CNT_MAX
		|=> compare_output_reg;
	endproperty
	a_fast_inv: assert property (p_fast_inv) else $error("not set on match");

	property p_fast_buffer;
		(waveform_mode_sel == tpwm_pkg::MODE_FAST_PWM) && $past(waveform_mode_sel) ==
		tpwm_pkg::MODE_FAST_PWM && !$past(timer_clock_enable && is_max)
		|-> $stable(compare_value_reg);
	endproperty
	a_fast_buffer: assert property (p_fast_buffer) else $error("compare loaded early");

	property p_pin_gate;
		!pin_cfg_reg[tpwm_pkg::PIN_DIR_BIT] ##1 pin_cfg_reg[tpwm_pkg::PIN_DIR_BIT] &&
		compare_out_mode != tpwm_pkg::COM_OFF
		|-> compare_output_pin_oe && compare_output_pin == compare_output_reg;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin not driven by waveform");

endmodule // tpwm_core

// [tpwm_pin_load.sv]
// Load circuit on the waveform pin, with a pull-down on the pad
`timescale 1ns/1ps
module tpwm_pin_load (
	// Pin from the timer
	input wire logic pin_value,
	input wire logic pin_oe,
	// Level seen by the load
	output logic pad_level
);
	// An undriven pin falls to the pull-down level
	assign pad_level = pin_oe ? pin_value : 1'b0;
endmodule // tpwm_pin_load

// [timer8_pwm_waveform_modes_tb.sv]
// Self-checking testbench for the 8-bit PWM timer
`timescale 1ns/1ps
module timer8_pwm_waveform_modes_tb;
	localparam logic [1:0] FAST = tpwm_pkg::MODE_FAST_PWM;
	localparam logic [1:0] PHC = tpwm_pkg::MODE_PC_PWM;
	localparam logic [1:0] TGL = tpwm_pkg::COM_TOGGLE;
	localparam logic [1:0] CLR = tpwm_pkg::COM_CLEAR;
	localparam logic [1:0] SETM = tpwm_pkg::COM_SET;
	localparam logic [2:0] STP = tpwm_pkg::CS_STOP;
	localparam logic [2:0] D1 = tpwm_pkg::CS_DIV1;
	localparam logic [2:0] D8 = tpwm_pkg::CS_DIV8;
	localparam logic [7:0] A_CTRL = tpwm_pkg::ADDR_CTRL;
	localparam logic [7:0] A_CNT = tpwm_pkg::ADDR_COUNT;
	localparam logic [7:0] A_CMP = tpwm_pkg::ADDR_CMP;
	localparam logic [7:0] A_FLG = tpwm_pkg::ADDR_FLAGS;
	localparam logic [7:0] A_PIN = tpwm_pkg::ADDR_PIN;

	typedef struct {
		logic [1:0] mode;
		logic [1:0] com;
		logic [2:0] cs;
		logic [7:0] cmp;
		int hi;
		int per;
	} tpwm_case_t;

	// Waveform cases; a period of zero means a constant level of hi
	tpwm_case_t cases[12] = '{
		'{FAST, CLR, D1, 8'h80, 129, 256},
		'{FAST, SETM, D1, 8'h80, 127, 256},
		'{FAST, CLR, D1, 8'h00, 1, 256},
		'{FAST, TGL, D1, 8'h00, 256, 512},
		'{FAST, CLR, D8, 8'h10, 136, 2048},
		'{PHC, CLR, D1, 8'h80, 256, 510},
		'{PHC, SETM, D1, 8'h40, 382, 510},
		'{FAST, CLR, D1, 8'hFF, 1, 0},
		'{FAST, SETM, D1, 8'hFF, 0, 0},
		'{PHC, CLR, D1, 8'h00, 0, 0},
		'{PHC, SETM, D1, 8'h00, 1, 0},
		'{PHC, CLR, D1, 8'hFF, 1, 0}
	};
	logic [7:0] regs[5] = '{A_CTRL, A_CNT, A_CMP, A_FLG, A_PIN};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic pin_oe;
	logic pad;
	logic [31:0] rd;
	logic err;
	wire ext_clk = cyc[2];
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	int t0;
	int t1;
	int t2;

	always #12.5 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc <= cyc + 1;
	end

	tpwm_core #(.ADDR_WIDTH(8)) tpwm_core_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.timer_ext_clock(ext_clk),
		.compare_output_pin(pin),
		.compare_output_pin_oe(pin_oe)
	);

	tpwm_pin_load tpwm_pin_load_inst (
		.pin_value(pin),
		.pin_oe(pin_oe),
		.pad_level(pad)
	);

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One APB transfer: setup, access, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check_word(rd, exp);
	endtask

	function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] c, logic [2:0] s);
		return (32'(m) << tpwm_pkg::CTRL_MODE_LSB) | (32'(c) << tpwm_pkg::CTRL_COM_LSB)
			| (32'(s) << tpwm_pkg::CTRL_CS_LSB);
	endfunction

	task automatic cfg(input logic [1:0] m, input logic [1:0] c, input logic [2:0] s,
		input logic [7:0] v);
		apb(1'b1, A_CMP, {24'h000000, v});
		apb(1'b1, A_CTRL, ctl(m, c, s));
		repeat (600) @(posedge pclk);
	endtask

	// Count ticks from a stopped, cleared counter in normal mode
	task automatic tick_cnt(input logic [2:0] s, input int n, input logic [7:0] exp);
		apb(1'b1, A_CTRL, 32'h00000000);
		apb(1'b1, A_CNT, 32'h00000000);
		apb(1'b1, A_CTRL, ctl(2'h0, 2'h0, s));
		repeat (n) @(posedge pclk);
		rchk(A_CNT, {24'h000000, exp});
	endtask

	// Wait on falling clock edges until the pad shows the level
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		@(negedge pclk);
		while (pad !== v && n < 20000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 20000) begin
			failures++;
			$display("BAD time=%0t got=%h exp=%h", $time, pad, v);
		end
	endtask

	task automatic measure(input int h, input int p);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		t0 = cyc;
		wait_lvl(1'b0);
		t1 = cyc;
		wait_lvl(1'b1);
		t2 = cyc;
		check_word(32'(t1 - t0), 32'(h));
		check_word(32'(t2 - t0), 32'(p));
	endtask

	task automatic hold_lvl(input logic v);
		int bad;
		bad = 0;
		repeat (600) begin
			@(negedge pclk);
			if (pad !== v) bad++;
		end
		check_word(32'(bad), 32'h00000000);
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		failures++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped address, write-only strobe and upper bits
		foreach (regs[i]) begin
			rchk(regs[i], 32'h00000000);
		end
		rchk(8'h14, 32'h00000000);
		check_bit(err, 1'b1);
		check_bit(pready, 1'b1);
		apb(1'b1, A_CTRL, 32'h00000080);
		rchk(A_CTRL, 32'h00000000);
		apb(1'b1, A_CMP, 32'hFFFFFF5A);
		rchk(A_CMP, 32'h0000005A);
		// Phase correct started above the compare value
		apb(1'b1, A_PIN, 32'h00000001);
		apb(1'b1, A_CMP, 32'h00000080);
		apb(1'b1, A_CNT, 32'h000000F0);
		apb(1'b1, A_CTRL, ctl(PHC, SETM, STP));
		apb(1'b1, A_FLG, 32'h00000003);
		rchk(A_FLG, 32'h00000000);
		apb(1'b1, A_CTRL, ctl(PHC, SETM, D1));
		repeat (20) @(posedge pclk);
		rchk(A_FLG, 32'h00000000);
		@(negedge pclk);
		check_bit(pad, 1'b1);
		repeat (300) @(posedge pclk);
		rchk(A_FLG, 32'h00000003);
		// Fast mode flags its overflow at the top
		apb(1'b1, A_CTRL, ctl(FAST, CLR, STP));
		apb(1'b1, A_CNT, 32'h000000F0);
		apb(1'b1, A_FLG, 32'h00000003);
		apb(1'b1, A_CTRL, ctl(FAST, CLR, D1));
		repeat (30) @(posedge pclk);
		rchk(A_FLG, 32'h00000001);
		// Pin direction gates the pad
		apb(1'b1, A_CTRL, 32'h00000000);
		apb(1'b1, A_PIN, 32'h00000002);
		@(negedge pclk);
		check_bit(pin_oe, 1'b0);
		check_bit(pad, 1'b0);
		apb(1'b1, A_PIN, 32'h00000003);
		@(negedge pclk);
		check_bit(pin_oe, 1'b1);
		check_bit(pad, 1'b1);
		apb(1'b1, A_PIN, 32'h00000001);
		// Prescaler taps and external edges as tick sources
		tick_cnt(tpwm_pkg::CS_DIV64, 199, 8'h03);
		tick_cnt(tpwm_pkg::CS_DIV256, 599, 8'h02);
		tick_cnt(tpwm_pkg::CS_DIV1024, 1099, 8'h01);
		tick_cnt(tpwm_pkg::CS_EXT_RISE, 199, 8'h19);
		tick_cnt(tpwm_pkg::CS_EXT_FALL, 199, 8'h19);
		foreach (cases[i]) begin
			cfg(cases[i].mode, cases[i].com, cases[i].cs, cases[i].cmp);
			if (cases[i].per == 0) begin
				hold_lvl(cases[i].hi[0]);
			end else begin
				measure(cases[i].hi, cases[i].per);
			end
		end
		// Leaving compare at max drops the output at the top
		apb(1'b1, A_CMP, 32'h00000080);
		wait_lvl(1'b0);
		t0 = cyc;
		wait_lvl(1'b1);
		check_word(32'(cyc - t0), 32'd127);
		// A compare write in mid-period waits for the next bottom
		cfg(FAST, CLR, D1, 8'h80);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		t0 = cyc;
		repeat (64) @(posedge pclk);
		apb(1'b1, A_CMP, 32'h00000020);
		wait_lvl(1'b0);
		check_word(32'(cyc - t0), 32'd129);
		wait_lvl(1'b1);
		t0 = cyc;
		wait_lvl(1'b0);
		check_word(32'(cyc - t0), 32'd33);
		finish_test();
	end
endmodule // timer8_pwm_waveform_modes_tb
